// *** rtl/operand_addressing_decode.sv ***
`timescale 1ns/1ns
// Contract
// - first field destination, second field source
// - four kinds: immediate, register, direct, indirect
// - operate on registers or register plus memory
// - immediate field embedded, destination width or narrower
// - equal-width immediate passes unchanged
// - narrow signed immediate sign-extended
// - narrow unsigned immediate zero-extended
// - immediate never accepted as destination
// - immediates come via fetch path only
// - sixteen general registers, indices zero to fifteen
// - registers full 32 bits wide
// - long divide reads 64-bit register pair
// - wide multiplies 64-bit, plain multiply 32-bit
// - signed, unsigned, and long unsigned divides
// - carry-in add, subtract, compare, zero-compare
// - shifts with extended forms, plus rotate left
module operand_addressing_decode
	import opdec_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic dec_valid,
	input wire op_class_t dec_op,
	input wire logic dec_two_operands,
	input wire addr_mode_t dec_dst_mode,
	input wire addr_mode_t dec_src_mode,
	input wire logic [REG_IDX_W-1:0] dec_dst_field,
	input wire logic [REG_IDX_W-1:0] dec_src_field,
	input wire logic [DATA_W-1:0] dec_addr_field,
	input wire logic [IMM_FIELD_W-1:0] fetch_imm,
	input wire op_size_t fetch_imm_size,
	input wire logic fetch_imm_signed,
	input wire op_size_t dec_dst_size,
	input wire logic wb_en,
	input wire logic [REG_IDX_W-1:0] wb_index,
	input wire logic [DATA_W-1:0] wb_data,
	output logic out_valid,
	output logic out_illegal,
	output op_class_t out_op,
	output addr_mode_t out_dst_mode,
	output addr_mode_t out_src_mode,
	output logic [REG_IDX_W-1:0] out_dst_index,
	output logic [DATA_W-1:0] out_dst_value,
	output logic [DATA_W-1:0] out_src_value,
	output logic [DATA_W-1:0] out_pair_low,
	output logic [DATA_W-1:0] out_mem_addr,
	output logic [1:0] out_result_kind
);
	logic [DATA_W-1:0] imm_value;
	logic [DATA_W-1:0] rd_a_data;
	logic [DATA_W-1:0] rd_b_data;
	logic [DATA_W-1:0] rd_pair_low;

	logic next_valid;
	logic next_illegal;
	op_class_t next_op;
	addr_mode_t next_dst_mode;
	addr_mode_t next_src_mode;
	logic [REG_IDX_W-1:0] next_dst_index;
	logic [DATA_W-1:0] next_dst_value;
	logic [DATA_W-1:0] next_src_value;
	logic [DATA_W-1:0] next_pair_low;
	logic [DATA_W-1:0] next_mem_addr;
	logic [1:0] next_result_kind;

	// result family for the execution unit, used by decode only; the checks name the classes directly
	function automatic logic [1:0] result_kind_of(input op_class_t op);
		case (op)
			OP_SIGNED_WIDE_MULTIPLY, OP_UNSIGNED_WIDE_MULTIPLY: result_kind_of = RESULT_WIDE;
			OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE, OP_LONG_UNSIGNED_DIVIDE: result_kind_of = RESULT_DIVIDE;
			default: result_kind_of = RESULT_NARROW;
		endcase
	endfunction

	// single-operand classes: source field is ignored
	function automatic logic is_single_operand(input op_class_t op);
		case (op)
			OP_ZERO_COMPARE, OP_ZERO_COMPARE_CARRY_IN, OP_ROTATE_LEFT: is_single_operand = 1'b1;
			default: is_single_operand = 1'b0;
		endcase
	endfunction

	// immediate comes only from the fetch bytes, never a data read
	immediate_extend u_imm
	(
		.imm_field(fetch_imm),
		.field_size(fetch_imm_size),
		.dest_size(dec_dst_size),
		.imm_signed(fetch_imm_signed),
		.imm_value(imm_value)
	);

	// port a reads the destination field, port b the source field
	general_register_file u_regs
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.wr_en(wb_en),
		.wr_index(wb_index),
		.wr_data(wb_data),
		.rd_a_index(dec_dst_field),
		.rd_b_index(dec_src_field),
		.rd_a_data(rd_a_data),
		.rd_b_data(rd_b_data),
		.rd_pair_low(rd_pair_low)
	);

	// decode one instruction per valid cycle
	always_comb
	begin
		next_valid = dec_valid;
		next_illegal = 1'b0;
		next_op = dec_op;
		next_dst_mode = dec_dst_mode;
		next_src_mode = dec_src_mode;
		next_dst_index = dec_dst_field;
		next_dst_value = DATA_RESET;
		next_src_value = DATA_RESET;
		next_pair_low = DATA_RESET;
		next_mem_addr = DATA_RESET;
		next_result_kind = result_kind_of(dec_op);
		if (dec_valid)
		begin
			// destination operand
			case (dec_dst_mode)
				MODE_IMMEDIATE: next_illegal = 1'b1;
				MODE_REGISTER: next_dst_value = rd_a_data;
				MODE_DIRECT: next_mem_addr = dec_addr_field;
				MODE_INDIRECT: next_mem_addr = rd_a_data + dec_addr_field;
				default: next_illegal = 1'b1;
			endcase
			// source operand only for two-operand forms
			if (dec_two_operands && !is_single_operand(dec_op))
			begin
				case (dec_src_mode)
					MODE_IMMEDIATE: next_src_value = imm_value;
					MODE_REGISTER: next_src_value = rd_b_data;
					MODE_DIRECT: next_mem_addr = dec_addr_field;
					MODE_INDIRECT: next_mem_addr = rd_b_data + dec_addr_field;
					default: next_illegal = 1'b1;
				endcase
				// at most one memory operand per instruction
				if (dec_dst_mode[1] && dec_src_mode[1])
					next_illegal = 1'b1;
			end
			else
				next_src_mode = MODE_IMMEDIATE;
			// long divide dividend: even base upper, odd neighbour lower
			if (dec_op == OP_LONG_UNSIGNED_DIVIDE)
			begin
				if (dec_dst_mode != MODE_REGISTER || dec_dst_field[0])
					next_illegal = 1'b1;
				next_pair_low = rd_pair_low;
			end
		end
		// an illegal decode never forwards operand data
		if (next_illegal)
		begin
			next_dst_value = DATA_RESET;
			next_src_value = DATA_RESET;
			next_pair_low = DATA_RESET;
			next_mem_addr = DATA_RESET;
		end
	end

	// all outputs registered; clock enable freezes the stage
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_valid <= 1'b0;
			out_illegal <= 1'b0;
			out_op <= OP_ADD;
			out_dst_mode <= MODE_REGISTER;
			out_src_mode <= MODE_IMMEDIATE;
			out_dst_index <= '0;
			out_dst_value <= DATA_RESET;
			out_src_value <= DATA_RESET;
			out_pair_low <= DATA_RESET;
			out_mem_addr <= DATA_RESET;
			out_result_kind <= RESULT_NARROW;
		end
		else if (clk_en)
		begin
			out_valid <= next_valid;
			out_illegal <= next_illegal;
			out_op <= next_op;
			out_dst_mode <= next_dst_mode;
			out_src_mode <= next_src_mode;
			out_dst_index <= next_dst_index;
			out_dst_value <= next_dst_value;
			out_src_value <= next_src_value;
			out_pair_low <= next_pair_low;
			out_mem_addr <= next_mem_addr;
			out_result_kind <= next_result_kind;
		end
	end

	// immediate destination is flagged on the next enabled edge
	property p_imm_dst_illegal;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_valid && dec_dst_mode == MODE_IMMEDIATE) |=> out_illegal;
	endproperty
	a_imm_dst_illegal: assert property (p_imm_dst_illegal) else $error("immediate destination not flagged");

	// odd pair base rejected
	property p_odd_pair;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_valid && dec_op == OP_LONG_UNSIGNED_DIVIDE && dec_dst_field[0]) |=> out_illegal;
	endproperty
	a_odd_pair: assert property (p_odd_pair) else $error("odd register pair accepted");

	// wide multiplies report a 64-bit result
	property p_wide_mul;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && (dec_op == OP_SIGNED_WIDE_MULTIPLY || dec_op == OP_UNSIGNED_WIDE_MULTIPLY))
			|=> out_result_kind == RESULT_WIDE;
	endproperty
	a_wide_mul: assert property (p_wide_mul) else $error("wide multiply result kind wrong");

	// plain multiply stays narrow
	property p_plain_mul;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_op == OP_PLAIN_MULTIPLY) |=> out_result_kind == RESULT_NARROW;
	endproperty
	a_plain_mul: assert property (p_plain_mul) else $error("plain multiply result kind wrong");

	// every divide class takes the divide path
	property p_divide;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_op inside {OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE, OP_LONG_UNSIGNED_DIVIDE})
			|=> out_result_kind == RESULT_DIVIDE;
	endproperty
	a_divide: assert property (p_divide) else $error("divide result kind wrong");

	// immediate source value matches the extender
	sequence s_imm_src;
		clk_en && dec_valid && dec_two_operands && !is_single_operand(dec_op) && dec_src_mode == MODE_IMMEDIATE
			&& dec_dst_mode == MODE_REGISTER && dec_op != OP_LONG_UNSIGNED_DIVIDE;
	endsequence
	property p_imm_src;
		@(posedge ref_clk) disable iff (!rstn)
		s_imm_src |=> out_src_value == $past(imm_value);
	endproperty
	a_imm_src: assert property (p_imm_src) else $error("immediate source value wrong");

	// register destination forwards the full 32-bit register
	property p_reg_dst;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_valid && dec_dst_mode == MODE_REGISTER && dec_op != OP_LONG_UNSIGNED_DIVIDE)
			|=> out_dst_value == $past(rd_a_data) && out_dst_index == $past(dec_dst_field);
	endproperty
	a_reg_dst: assert property (p_reg_dst) else $error("register destination value wrong");

	// two memory operands never pass
	property p_one_memory;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_valid && dec_two_operands && !is_single_operand(dec_op)
			&& dec_dst_mode[1] && dec_src_mode[1]) |=> out_illegal;
	endproperty
	a_one_memory: assert property (p_one_memory) else $error("two memory operands accepted");

	// frozen stage holds its valid and source value outputs
	property p_hold;
		@(posedge ref_clk) disable iff (!rstn)
		!clk_en |=> $stable(out_valid) && $stable(out_src_value);
	endproperty
	a_hold: assert property (p_hold) else $error("outputs moved while disabled");

	// result valid follows the request one enabled edge later
	property p_valid_follow;
		@(posedge ref_clk) disable iff (!rstn)
		clk_en |=> out_valid == $past(dec_valid);
	endproperty
	a_valid_follow: assert property (p_valid_follow) else $error("result valid does not follow request");

	// a refused decode forwards no operand data
	property p_illegal_clear;
		@(posedge ref_clk) disable iff (!rstn)
		out_illegal |-> out_dst_value == DATA_RESET && out_src_value == DATA_RESET && out_pair_low == DATA_RESET
			&& out_mem_addr == DATA_RESET;
	endproperty
	a_illegal_clear: assert property (p_illegal_clear) else $error("refused decode forwarded data");

	// legal long divide takes its low half from the odd neighbour
	sequence s_pair_req;
		clk_en && dec_valid && dec_op == OP_LONG_UNSIGNED_DIVIDE
			&& dec_dst_mode == MODE_REGISTER && !dec_dst_field[0];
	endsequence
	property p_pair_low;
		@(posedge ref_clk) disable iff (!rstn)
		s_pair_req |=> !out_illegal && out_pair_low == $past(rd_pair_low);
	endproperty
	a_pair_low: assert property (p_pair_low) else $error("register pair low half wrong");

	// single-operand forms never forward a source
	property p_single_src;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_valid && (!dec_two_operands || is_single_operand(dec_op)))
			|=> out_src_mode == MODE_IMMEDIATE && out_src_value == DATA_RESET;
	endproperty
	a_single_src: assert property (p_single_src) else $error("single operand form forwarded a source");

	// direct destination addresses memory with the address field as given
	property p_direct_addr;
		@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dec_valid && dec_dst_mode == MODE_DIRECT && !dec_src_mode[1]
			&& dec_op != OP_LONG_UNSIGNED_DIVIDE) |=> out_mem_addr == $past(dec_addr_field);
	endproperty
	a_direct_addr: assert property (p_direct_addr) else $error("direct address not forwarded");
endmodule

// *** rtl/opdec_pkg.sv ***
package opdec_pkg;
	// operand field and register file geometry
	localparam int REG_COUNT = 16;
	localparam int REG_IDX_W = 4;
	localparam int DATA_W = 32;
	localparam int WIDE_W = 64;
	localparam int IMM_FIELD_W = 32;
	localparam logic [31:0] DATA_RESET = 32'h00000000;

	// operand addressing kinds
	typedef enum logic [1:0]
	{
		MODE_IMMEDIATE = 2'b00,
		MODE_REGISTER = 2'b01,
		MODE_DIRECT = 2'b10,
		MODE_INDIRECT = 2'b11
	} addr_mode_t;

	// destination and embedded field widths
	typedef enum logic [1:0]
	{
		SIZE_BYTE = 2'b00,
		SIZE_WORD = 2'b01,
		SIZE_QUAD = 2'b10,
		SIZE_NONE = 2'b11
	} op_size_t;

	// operation classes the decoder routes to the execution unit
	typedef enum logic [4:0]
	{
		OP_ADD = 5'h00,
		OP_ADD_CARRY_IN = 5'h01,
		OP_SUBTRACT = 5'h02,
		OP_SUBTRACT_CARRY_IN = 5'h03,
		OP_COMPARE = 5'h04,
		OP_COMPARE_CARRY_IN = 5'h05,
		OP_ZERO_COMPARE = 5'h06,
		OP_ZERO_COMPARE_CARRY_IN = 5'h07,
		OP_PLAIN_MULTIPLY = 5'h08,
		OP_SIGNED_WIDE_MULTIPLY = 5'h09,
		OP_UNSIGNED_WIDE_MULTIPLY = 5'h0a,
		OP_SIGNED_DIVIDE = 5'h0b,
		OP_UNSIGNED_DIVIDE = 5'h0c,
		OP_LONG_UNSIGNED_DIVIDE = 5'h0d,
		OP_LEFT_LOGICAL_SHIFT = 5'h0e,
		OP_LEFT_LOGICAL_SHIFT_EXTENDED = 5'h0f,
		OP_RIGHT_LOGICAL_SHIFT = 5'h10,
		OP_RIGHT_LOGICAL_SHIFT_EXTENDED = 5'h11,
		OP_RIGHT_ARITH_SHIFT = 5'h12,
		OP_RIGHT_ARITH_SHIFT_EXTENDED = 5'h13,
		OP_ROTATE_LEFT = 5'h14,
		OP_LOAD = 5'h15
	} op_class_t;

	// result width per operation family
	localparam logic [1:0] RESULT_NARROW = 2'b00;
	localparam logic [1:0] RESULT_WIDE = 2'b01;
	localparam logic [1:0] RESULT_DIVIDE = 2'b10;
endpackage

// *** rtl/immediate_extend.sv ***
`timescale 1ns/1ns
module immediate_extend
	import opdec_pkg::*;
(
	input wire logic [IMM_FIELD_W-1:0] imm_field,
	input wire op_size_t field_size,
	input wire op_size_t dest_size,
	input wire logic imm_signed,
	output logic [DATA_W-1:0] imm_value
);
	logic [DATA_W-1:0] raw;
	logic sign_bit;

	// cut the field to its width, then extend to the destination size
	always_comb
	begin
		raw = imm_field;
		sign_bit = 1'b0;
		case (field_size)
			SIZE_BYTE:
			begin
				raw = {24'h000000, imm_field[7:0]};
				sign_bit = imm_field[7];
			end
			SIZE_WORD:
			begin
				raw = {16'h0000, imm_field[15:0]};
				sign_bit = imm_field[15];
			end
			default:
			begin
				raw = imm_field;
				sign_bit = imm_field[31];
			end
		endcase
		imm_value = raw;
		if (field_size != dest_size && imm_signed)
		begin
			if (field_size == SIZE_BYTE)
				imm_value = {{24{sign_bit}}, raw[7:0]};
			else if (field_size == SIZE_WORD)
				imm_value = {{16{sign_bit}}, raw[15:0]};
		end
		// unsigned narrower field keeps the zero fill in raw: equal width passes
		// clip to the destination width so upper bits never leak
		case (dest_size)
			SIZE_BYTE: imm_value = {24'h000000, imm_value[7:0]};
			SIZE_WORD: imm_value = {16'h0000, imm_value[15:0]};
			default: imm_value = imm_value;
		endcase
	end
endmodule

// *** rtl/general_register_file.sv ***
`timescale 1ns/1ns
module general_register_file
	import opdec_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [REG_IDX_W-1:0] wr_index,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [REG_IDX_W-1:0] rd_a_index,
	input wire logic [REG_IDX_W-1:0] rd_b_index,
	output logic [DATA_W-1:0] rd_a_data,
	output logic [DATA_W-1:0] rd_b_data,
	output logic [DATA_W-1:0] rd_pair_low
);
	logic [DATA_W-1:0] regs [REG_COUNT];
	logic [DATA_W-1:0] next_regs [REG_COUNT];

	// sixteen full-width registers, one write port
	genvar g;
	generate
		for (g = 0; g < REG_COUNT; g++)
		begin : g_reg
			always_comb
			begin
				next_regs[g] = regs[g];
				if (wr_en && wr_index == REG_IDX_W'(g))
					next_regs[g] = wr_data;
			end
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					regs[g] <= DATA_RESET;
				else if (clk_en)
					regs[g] <= next_regs[g];
			end
		end
	endgenerate

	// pair low half is the odd neighbour of the even base
	assign rd_a_data = regs[rd_a_index];
	assign rd_b_data = regs[rd_b_index];
	assign rd_pair_low = regs[{rd_a_index[REG_IDX_W-1:1], 1'b1}];
endmodule

// *** test/exec_writeback_model.sv ***
`timescale 1ns/1ns
module exec_writeback_model
	import opdec_pkg::*;
(
	input wire logic ref_clk,
	output logic wb_en,
	output logic [REG_IDX_W-1:0] wb_index,
	output logic [DATA_W-1:0] wb_data
);
	// bus idles low until the first write
	initial
	begin
		wb_en = 1'b0;
		wb_index = 4'h0;
		wb_data = 32'h0;
	end
	// one write pulse after gap plus one idle cycles; idle bus shows the inverse, never a stale copy
	task automatic put(input logic [REG_IDX_W-1:0] idx, input logic [DATA_W-1:0] val, input int gap);
		repeat (gap + 1) @(negedge ref_clk);
		wb_en = 1'b1;
		wb_index = idx;
		wb_data = val;
		@(negedge ref_clk);
		wb_en = 1'b0;
		wb_index = ~idx;
		wb_data = ~val;
	endtask
endmodule

// *** test/test_operand_addressing_decode.sv ***
`timescale 1ns/1ns
module test_operand_addressing_decode
	import opdec_pkg::*;
;
	typedef struct {logic ill; op_class_t op; logic [31:0] dv, sv, pl, ma; logic [1:0] rk; logic [3:0] di;
		addr_mode_t dm, sm; logic [5:0] m;} exp_t;
	logic ref_clk, rstn, clk_en, en_seen, dec_valid, dec_two_operands, fetch_imm_signed, wb_en, out_valid, out_illegal;
	op_class_t dec_op, out_op;
	addr_mode_t dec_dst_mode, dec_src_mode, out_dst_mode, out_src_mode;
	logic [3:0] dec_dst_field, dec_src_field, wb_index, out_dst_index;
	logic [31:0] dec_addr_field, fetch_imm, wb_data, out_dst_value, out_src_value, out_pair_low, out_mem_addr, seed;
	op_size_t fetch_imm_size, dec_dst_size;
	logic [1:0] out_result_kind;
	logic [31:0] regs [16];
	exp_t q[$];
	exp_t e, g;
	int mismatches, n_compared;

	operand_addressing_decode dut (.ref_clk, .rstn, .clk_en, .dec_valid, .dec_op, .dec_two_operands,
		.dec_dst_mode, .dec_src_mode, .dec_dst_field, .dec_src_field, .dec_addr_field, .fetch_imm, .fetch_imm_size,
		.fetch_imm_signed, .dec_dst_size, .wb_en, .wb_index, .wb_data, .out_valid, .out_illegal, .out_op,
		.out_dst_mode, .out_src_mode, .out_dst_index, .out_dst_value, .out_src_value, .out_pair_low, .out_mem_addr,
		.out_result_kind);
	exec_writeback_model wbm (.ref_clk, .wb_en, .wb_index, .wb_data);

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// extend by field width, then clip to the destination width
	function automatic logic [31:0] ext(logic [31:0] v, int fs, int ds, logic sg);
		logic [31:0] r;
		r = fs == 0 ? {{24{sg & v[7]}}, v[7:0]} : fs == 1 ? {{16{sg & v[15]}}, v[15:0]} : v;
		if (ds == 0)
			r = {24'h0, r[7:0]};
		else if (ds == 1)
			r = {16'h0, r[15:0]};
		return r;
	endfunction

	task automatic check(string n, logic [31:0] s, logic [31:0] x);
		n_compared++;
		if (s !== x)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask

	task automatic finish_test();
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// fields of one instruction, set on the falling edge
	task automatic dec(op_class_t op, addr_mode_t dm, addr_mode_t sm, logic [3:0] df, logic [3:0] sf);
		dec_op = op;
		dec_dst_mode = dm;
		dec_src_mode = sm;
		dec_dst_field = df;
		dec_src_field = sf;
		e = '{ill: 1'b0, op: op, dv: 32'h0, sv: 32'h0, pl: 32'h0, ma: 32'h0, rk: 2'h0, di: df, dm: dm, sm: sm, m: 6'h0};
		// no source without a second operand; single-operand classes drop it too
		if (!dec_two_operands || op inside {OP_ZERO_COMPARE, OP_ZERO_COMPARE_CARRY_IN, OP_ROTATE_LEFT})
			e.sm = MODE_IMMEDIATE;
	endtask

	task automatic send();
		dec_valid = 1'b1;
		q.push_back(e);
		@(negedge ref_clk);
	endtask

	// enable as the stage saw it, so a frozen result is not retired twice
	always @(posedge ref_clk)
	begin
		en_seen <= clk_en;
	end

	// watcher: each fresh result retires the oldest note; a frozen stage must hold the last one
	always @(negedge ref_clk)
	begin
		if (out_valid === 1'b1 && en_seen !== 1'b1)
			check("out_dst_value", out_dst_value, g.dv);
		else if (out_valid === 1'b1)
		begin
			if (q.size() == 0)
				check("out_valid", 32'(out_valid), 32'h0);
			else
			begin
				g = q.pop_front();
				check("out_illegal", 32'(out_illegal), 32'(g.ill));
				check("out_op", 32'(out_op), 32'(g.op));
				if (g.m[0]) check("out_dst_value", out_dst_value, g.dv);
				if (g.m[1]) check("out_src_value", out_src_value, g.sv);
				if (g.m[2]) check("out_pair_low", out_pair_low, g.pl);
				if (g.m[3]) check("out_mem_addr", out_mem_addr, g.ma);
				if (g.m[4]) check("out_result_kind", 32'(out_result_kind), 32'(g.rk));
				if (g.m[5]) check("out_dst_index", 32'(out_dst_index), 32'(g.di));
				if (g.m[5]) check("out_dst_mode", 32'(out_dst_mode), 32'(g.dm));
				if (g.m[5]) check("out_src_mode", 32'(out_src_mode), 32'(g.sm));
			end
		end
	end

	initial
	begin
		{rstn, dec_valid, fetch_imm_signed, dec_dst_field, dec_src_field, fetch_imm} = '0;
		dec_two_operands = 1'b1;
		clk_en = 1'b1;
		dec_op = OP_ADD;
		dec_dst_mode = MODE_REGISTER;
		dec_src_mode = MODE_REGISTER;
		fetch_imm_size = SIZE_QUAD;
		dec_dst_size = SIZE_QUAD;
		seed = 32'h3acd;
		dec_addr_field = seed;
		repeat (12) @(posedge ref_clk);
		check("out_valid", 32'(out_valid), 32'h0);
		check("out_dst_mode", 32'(out_dst_mode), 32'(MODE_REGISTER));
		check("out_src_mode", 32'(out_src_mode), 32'(MODE_IMMEDIATE));
		@(negedge ref_clk);
		rstn = 1'b1;
		// fill all sixteen registers with full-width values, some writes stalled
		for (int i = 0; i < 16; i++)
		begin
			seed = lfsr(seed);
			regs[i] = seed;
			wbm.put(i[3:0], seed, i % 3);
		end
		// register to register, every index on both fields, back to back
		for (int i = 0; i < 16; i++)
		begin
			dec(OP_ADD, MODE_REGISTER, MODE_REGISTER, i[3:0], 4'(15 - i));
			e.dv = regs[i];
			e.sv = regs[15 - i];
			e.m = 6'h23;
			send();
		end
		// immediate source: every field width, destination width and signedness
		for (int k = 0; k < 18; k++)
		begin
			dec(OP_ADD, MODE_REGISTER, MODE_IMMEDIATE, 4'h5, 4'h0);
			seed = lfsr(seed);
			fetch_imm = {seed[15:0], seed[31:16]};
			fetch_imm_size = op_size_t'(k / 6);
			dec_dst_size = op_size_t'((k / 2) % 3);
			fetch_imm_signed = k[0];
			e.sv = ext(fetch_imm, k / 6, (k / 2) % 3, k[0]);
			e.m = 6'h02;
			send();
		end
		dec_dst_size = SIZE_QUAD;
		// every operation class with its result width
		for (int k = 0; k < 22; k++)
		begin
			dec(op_class_t'(k), MODE_REGISTER, MODE_REGISTER, 4'h2, 4'h7);
			e.rk = (k == 9 || k == 10) ? 2'h1 : (k >= 11 && k <= 13) ? 2'h2 : 2'h0;
			e.dv = regs[2];
			e.sv = (k == 6 || k == 7 || k == 20) ? 32'h0 : regs[7];
			e.pl = regs[3];
			e.m = k == 13 ? 6'h37 : 6'h33;
			send();
		end
		// refused: odd pair base, memory pair, immediate destination, two memory operands
		dec(OP_LONG_UNSIGNED_DIVIDE, MODE_REGISTER, MODE_REGISTER, 4'h5, 4'h0);
		e.ill = 1'b1;
		e.m = 6'h0f;
		send();
		dec(OP_LONG_UNSIGNED_DIVIDE, MODE_DIRECT, MODE_REGISTER, 4'h4, 4'h0);
		e.ill = 1'b1;
		e.m = 6'h0f;
		send();
		dec(OP_ADD, MODE_IMMEDIATE, MODE_REGISTER, 4'h1, 4'h2);
		e.ill = 1'b1;
		e.m = 6'h0f;
		send();
		dec(OP_ADD, MODE_DIRECT, MODE_INDIRECT, 4'h1, 4'h2);
		e.ill = 1'b1;
		e.m = 6'h0f;
		send();
		// memory operands: direct source, indirect source, direct destination
		dec(OP_LOAD, MODE_REGISTER, MODE_DIRECT, 4'h1, 4'h0);
		e.ma = dec_addr_field;
		e.m = 6'h29;
		e.dv = regs[1];
		send();
		dec(OP_LOAD, MODE_REGISTER, MODE_INDIRECT, 4'h1, 4'h9);
		e.ma = regs[9] + dec_addr_field;
		e.m = 6'h08;
		send();
		dec(OP_ADD, MODE_DIRECT, MODE_REGISTER, 4'h0, 4'h4);
		e.ma = dec_addr_field;
		e.sv = regs[4];
		e.m = 6'h2a;
		send();
		// no second operand: source dropped even though its field names a register
		dec_two_operands = 1'b0;
		dec(OP_ADD, MODE_REGISTER, MODE_REGISTER, 4'h6, 4'h7);
		e.dv = regs[6];
		e.m = 6'h23;
		send();
		dec_two_operands = 1'b1;
		// clock enable low: the stage holds while the next fields wait
		dec(OP_ADD, MODE_REGISTER, MODE_REGISTER, 4'h8, 4'h9);
		e.dv = regs[8];
		e.sv = regs[9];
		e.m = 6'h23;
		send();
		clk_en = 1'b0;
		dec(OP_SUBTRACT, MODE_REGISTER, MODE_REGISTER, 4'ha, 4'hb);
		e.dv = regs[10];
		e.sv = regs[11];
		e.m = 6'h23;
		repeat (3) @(negedge ref_clk);
		clk_en = 1'b1;
		send();
		dec_valid = 1'b0;
		// bounded drain of outstanding results
		for (int i = 0; i < 20 && q.size() != 0; i++)
			@(negedge ref_clk);
		if (q.size() != 0)
			check("out_valid", 32'h0, 32'h1);
		finish_test();
	end
endmodule
